//--- rtl/ild_top.v
`timescale 1ns/1ns
`default_nettype none
`include "ild_consts.vh"
module ild_top #(
   parameter SAMPLE_W = 14,
   parameter HOLD_DEPTH = 7
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // converter sample buses and input enables
   input wire [SAMPLE_W-1:0] port_a_sample_bus,
   input wire [SAMPLE_W-1:0] port_b_sample_bus,
   input wire port_a_input_enable,
   input wire port_b_input_enable,
   // microport pins
   input wire up_mode,
   input wire up_cs_n,
   input wire up_rd_n,
   input wire up_wr_n,
   input wire [2:0] up_addr,
   input wire [7:0] up_data_in,
   output reg [7:0] up_data_out,
   output reg up_data_oe_n,
   output reg up_rdy,
   // level indicator pins
   output reg port_a_level_out_primary,
   output reg port_a_level_out_secondary,
   output reg port_b_level_out_primary,
   output reg port_b_level_out_secondary
);
   localparam [2:0] UP_IDLE = 3'b001;
   localparam [2:0] UP_BUSY = 3'b010;
   localparam [2:0] UP_DONE = 3'b100;

   localparam [2:0] DET_IDLE = 3'b001;
   localparam [2:0] DET_HELD = 3'b010;
   localparam [2:0] DET_DWELL = 3'b100;

   // external registers
   reg [7:0] data_reg1;
   reg [3:0] data_reg2;
   reg [7:0] sleep_register;
   reg [7:0] channel_address_register;
   reg [7:0] access_control_register;

   // detector map
   reg [9:0] port_a_low_threshold;
   reg [9:0] port_a_high_threshold;
   reg [19:0] port_a_dwell_count;
   reg [4:0] port_a_indicator_config;
   reg [9:0] port_b_low_threshold;
   reg [9:0] port_b_high_threshold;
   reg [19:0] port_b_dwell_count;
   reg [4:0] port_b_indicator_config;

   // microport sequencer
   reg [2:0] up_state;
   reg [2:0] up_timer;
   reg up_is_read;
   reg up_prev_strobe;

   wire [14:0] up_pins_raw;
   wire [14:0] up_pins;
   wire mode_s;
   wire cs_n_s;
   wire rd_n_s;
   wire wr_n_s;
   wire [2:0] addr_s;
   wire [7:0] din_s;
   wire strobe;
   wire read_req;
   wire start;

   // detector per-port signals, index 0 is port A
   wire [1:0] det_held;
   wire [1:0] det_late;
   wire [1:0] ilv;
   wire [1:0] pol;
   wire [1:0] ien;
   wire [1:0] next_prim;
   wire [1:0] next_sec;

   // strobes idle high, so the synchroniser starts high on those bits
   assign up_pins_raw = {up_mode, up_cs_n, up_rd_n, up_wr_n, up_addr, up_data_in};

   ild_sync3 #(
      .WIDTH(15),
      .INIT(15'h3800)
   ) u_up_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(up_pins_raw),
      .sync_out(up_pins)
   );

   assign mode_s = up_pins[14];
   assign cs_n_s = up_pins[13];
   assign rd_n_s = up_pins[12];
   assign wr_n_s = up_pins[11];
   assign addr_s = up_pins[10:8];
   assign din_s = up_pins[7:0];

   // mode 0: separate read and write strobes; mode 1: data strobe plus rw
   assign strobe = ~cs_n_s & (mode_s ? ~rd_n_s : (~rd_n_s | ~wr_n_s));
   assign read_req = mode_s ? wr_n_s : ~rd_n_s;
   assign start = strobe & ~up_prev_strobe & up_state[0];

   // detector location hit: alt map on, channel address inside it and access control bits 1:0 clear
   function map_hit;
      input [7:0] sleep_v;
      input [7:0] chan_v;
      input [7:0] acr_v;
      begin
         map_hit = sleep_v[`ILD_SLEEP_ALT_BIT] & (chan_v[7:3] == 5'h00) & (acr_v[1:0] == 2'h0);
      end
   endfunction

   function [19:0] map_read;
      input [2:0] loc;
      begin
         map_read = 20'h00000;
         if (loc == `ILD_LOC_A_LOW)
            map_read = {10'h000, port_a_low_threshold};
         else if (loc == `ILD_LOC_A_HIGH)
            map_read = {10'h000, port_a_high_threshold};
         else if (loc == `ILD_LOC_A_DWELL)
            map_read = port_a_dwell_count;
         else if (loc == `ILD_LOC_A_CFG)
            map_read = {15'h0000, port_a_indicator_config};
         else if (loc == `ILD_LOC_B_LOW)
            map_read = {10'h000, port_b_low_threshold};
         else if (loc == `ILD_LOC_B_HIGH)
            map_read = {10'h000, port_b_high_threshold};
         else if (loc == `ILD_LOC_B_DWELL)
            map_read = port_b_dwell_count;
         else
            map_read = {15'h0000, port_b_indicator_config};
      end
   endfunction

   // microport sequencer and register file
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         up_state <= UP_IDLE;
         up_timer <= 3'h0;
         up_is_read <= 1'b0;
         up_prev_strobe <= 1'b0;
         up_data_out <= 8'h00;
         up_data_oe_n <= 1'b1;
         up_rdy <= 1'b1;
         data_reg1 <= 8'h00;
         data_reg2 <= 4'h0;
         sleep_register <= `ILD_SLEEP_RESET;
         channel_address_register <= 8'h00;
         access_control_register <= 8'h00;
         port_a_low_threshold <= `ILD_THR_RESET;
         port_a_high_threshold <= `ILD_THR_RESET;
         port_a_dwell_count <= `ILD_DWELL_RESET;
         port_a_indicator_config <= `ILD_CFG_RESET;
         port_b_low_threshold <= `ILD_THR_RESET;
         port_b_high_threshold <= `ILD_THR_RESET;
         port_b_dwell_count <= `ILD_DWELL_RESET;
         port_b_indicator_config <= `ILD_CFG_RESET;
      end
      else
      begin
         up_prev_strobe <= strobe;
         case (up_state)
            UP_IDLE:
            begin
               up_rdy <= 1'b1;
               up_data_oe_n <= 1'b1;
               if (start)
               begin
                  up_state <= UP_BUSY;
                  up_timer <= `ILD_ACCESS_CYCLES;
                  up_is_read <= read_req;
                  // mode 0 ready drops at the start of the access
                  if (!mode_s)
                     up_rdy <= 1'b0;
                  if (read_req)
                  begin
                     up_data_oe_n <= 1'b0;
                     if (addr_s == `ILD_EXT_DR0)
                     begin
                        if (map_hit(sleep_register, channel_address_register,
                              access_control_register))
                        begin
                           {data_reg2, data_reg1, up_data_out} <=
                              map_read(channel_address_register[2:0]);
                        end
                        else
                        begin
                           // the normal map lives elsewhere and reads as zero here
                           up_data_out <= 8'h00;
                           data_reg1 <= 8'h00;
                           data_reg2 <= 4'h0;
                        end
                     end
                     else if (addr_s == `ILD_EXT_DR1)
                        up_data_out <= data_reg1;
                     else if (addr_s == `ILD_EXT_DR2)
                        up_data_out <= {4'h0, data_reg2};
                     else if (addr_s == `ILD_EXT_SLEEP)
                        up_data_out <= sleep_register;
                     else if (addr_s == `ILD_EXT_CHAN)
                        up_data_out <= channel_address_register;
                     else if (addr_s == `ILD_EXT_ACR)
                        up_data_out <= access_control_register;
                     else
                        up_data_out <= 8'h00;
                  end
                  else
                  begin
                     if (addr_s == `ILD_EXT_DR0)
                     begin
                        if (map_hit(sleep_register, channel_address_register,
                              access_control_register))
                        begin
                           if (channel_address_register[2:0] == `ILD_LOC_A_LOW)
                              port_a_low_threshold <= {data_reg1[1:0], din_s};
                           else if (channel_address_register[2:0] == `ILD_LOC_A_HIGH)
                              port_a_high_threshold <= {data_reg1[1:0], din_s};
                           else if (channel_address_register[2:0] == `ILD_LOC_A_DWELL)
                              port_a_dwell_count <= {data_reg2, data_reg1, din_s};
                           else if (channel_address_register[2:0] == `ILD_LOC_A_CFG)
                              port_a_indicator_config <= din_s[4:0];
                           else if (channel_address_register[2:0] == `ILD_LOC_B_LOW)
                              port_b_low_threshold <= {data_reg1[1:0], din_s};
                           else if (channel_address_register[2:0] == `ILD_LOC_B_HIGH)
                              port_b_high_threshold <= {data_reg1[1:0], din_s};
                           else if (channel_address_register[2:0] == `ILD_LOC_B_DWELL)
                              port_b_dwell_count <= {data_reg2, data_reg1, din_s};
                           else
                              port_b_indicator_config <= din_s[4:0];
                        end
                     end
                     else if (addr_s == `ILD_EXT_DR1)
                        data_reg1 <= din_s;
                     else if (addr_s == `ILD_EXT_DR2)
                        data_reg2 <= din_s[3:0];
                     else if (addr_s == `ILD_EXT_SLEEP)
                        sleep_register <= din_s;
                     else if (addr_s == `ILD_EXT_CHAN)
                        channel_address_register <= din_s;
                     else if (addr_s == `ILD_EXT_ACR)
                        access_control_register <= din_s;
                  end
               end
            end
            UP_BUSY:
            begin
               if (up_timer == 3'h1)
               begin
                  up_state <= UP_DONE;
                  // mode 0 releases ready, mode 1 acknowledges now
                  up_rdy <= mode_s ? 1'b0 : 1'b1;
               end
               else
                  up_timer <= up_timer - 3'h1;
            end
            UP_DONE:
            begin
               if (!strobe)
               begin
                  up_state <= UP_IDLE;
                  up_rdy <= 1'b1;
                  up_data_oe_n <= 1'b1;
               end
            end
            default:
            begin
               up_state <= UP_IDLE;
            end
         endcase
      end
   end

   assign ilv[0] = port_a_indicator_config[`ILD_CFG_ILV_BIT];
   assign ilv[1] = port_b_indicator_config[`ILD_CFG_ILV_BIT];
   assign pol[0] = port_a_indicator_config[`ILD_CFG_POL_BIT];
   assign pol[1] = port_b_indicator_config[`ILD_CFG_POL_BIT];
   assign ien[0] = port_a_input_enable;
   assign ien[1] = port_b_input_enable;

   // one detector per input port
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_det
         wire [SAMPLE_W-1:0] sample;
         wire [9:0] low_thr;
         wire [9:0] high_thr;
         wire [19:0] dwell;
         wire [2:0] hold_sel;
         wire [9:0] mant;
         wire low_met;
         wire high_met;
         reg [2:0] state;
         reg [19:0] count;

         // port B uses its own register set
         assign sample = (g == 0) ? port_a_sample_bus : port_b_sample_bus;
         assign low_thr = (g == 0) ? port_a_low_threshold : port_b_low_threshold;
         assign high_thr = (g == 0) ? port_a_high_threshold : port_b_high_threshold;
         assign dwell = (g == 0) ? port_a_dwell_count : port_b_dwell_count;
         assign hold_sel = (g == 0) ?
            port_a_indicator_config[`ILD_CFG_HOLD_MSB:`ILD_CFG_HOLD_LSB] :
            port_b_indicator_config[`ILD_CFG_HOLD_MSB:`ILD_CFG_HOLD_LSB];
         assign mant = sample[`ILD_MANT_MSB:`ILD_MANT_LSB];
         assign low_met = (mant <= low_thr);
         assign high_met = (mant >= high_thr);

         always @(posedge clk)
         begin
            if (sys_rst)
            begin
               state <= DET_IDLE;
               count <= 20'h00000;
            end
            else if (dwell == 20'h00000)
            begin
               state <= DET_IDLE;
               count <= 20'h00000;
            end
            else
            begin
               case (state)
                  DET_IDLE:
                  begin
                     if (high_met)
                        state <= DET_HELD;
                  end
                  DET_HELD:
                  begin
                     if (low_met)
                     begin
                        state <= DET_DWELL;
                        count <= dwell;
                     end
                  end
                  DET_DWELL:
                  begin
                     if (!low_met)
                     begin
                        state <= DET_HELD;
                        count <= dwell;
                     end
                     else if (count == 20'h00001)
                     begin
                        state <= DET_IDLE;
                        count <= 20'h00000;
                     end
                     else
                        count <= count - 20'h00001;
                  end
                  default:
                  begin
                     state <= DET_IDLE;
                  end
               endcase
            end
         end

         assign det_held[g] = ~state[0];

         ild_holdoff #(
            .DEPTH(HOLD_DEPTH),
            .SEL_W(3)
         ) u_hold (
            .clk(clk),
            .sys_rst(sys_rst),
            .det_in(det_held[g]),
            .delay_sel(hold_sel),
            .det_out(det_late[g])
         );

         assign next_prim[g] = ilv[g] ? (det_late[g] & ~ien[g]) : det_late[g];
         assign next_sec[g] = ilv[g] ? (det_late[g] & ien[g]) : ~det_late[g];
      end
   endgenerate

   // indicator pins, registered with polarity applied
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         port_a_level_out_primary <= pol[0];
         port_a_level_out_secondary <= pol[0];
         port_b_level_out_primary <= pol[1];
         port_b_level_out_secondary <= pol[1];
      end
      else
      begin
         port_a_level_out_primary <= next_prim[0] ^ pol[0];
         port_a_level_out_secondary <= next_sec[0] ^ pol[0];
         port_b_level_out_primary <= next_prim[1] ^ pol[1];
         port_b_level_out_secondary <= next_sec[1] ^ pol[1];
      end
   end
endmodule // ild_top
`default_nettype wire

//--- rtl/ild_consts.vh
`ifndef ILD_CONSTS_VH
`define ILD_CONSTS_VH

// external microport addresses
`define ILD_EXT_DR0 3'h0
`define ILD_EXT_DR1 3'h1
`define ILD_EXT_DR2 3'h2
`define ILD_EXT_SLEEP 3'h3
`define ILD_EXT_CHAN 3'h6
`define ILD_EXT_ACR 3'h7

// sleep register field: alternate map select
`define ILD_SLEEP_ALT_BIT 5
`define ILD_SLEEP_RESET 8'h00

// detector map locations (channel address)
`define ILD_LOC_A_LOW 3'h0
`define ILD_LOC_A_HIGH 3'h1
`define ILD_LOC_A_DWELL 3'h2
`define ILD_LOC_A_CFG 3'h3
`define ILD_LOC_B_LOW 3'h4
`define ILD_LOC_B_HIGH 3'h5
`define ILD_LOC_B_DWELL 3'h6
`define ILD_LOC_B_CFG 3'h7

// indicator config fields
`define ILD_CFG_POL_BIT 4
`define ILD_CFG_ILV_BIT 3
`define ILD_CFG_HOLD_MSB 2
`define ILD_CFG_HOLD_LSB 0

// reset values of the detector registers
`define ILD_THR_RESET 10'h000
`define ILD_DWELL_RESET 20'h00000
`define ILD_CFG_RESET 5'h00

// sample bits compared against the thresholds
`define ILD_MANT_MSB 13
`define ILD_MANT_LSB 4

// internal access time of the microport, in clk cycles
`define ILD_ACCESS_CYCLES 3'h2

`endif

//--- rtl/ild_sync3.v
`timescale 1ns/1ns
`default_nettype none
module ild_sync3 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // asynchronous input and its clean copy
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         // only a value seen on two stages in a row is passed on
         if (stage2 == stage3)
            sync_out <= stage3;
      end
   end
endmodule // ild_sync3
`default_nettype wire

//--- rtl/ild_holdoff.v
`timescale 1ns/1ns
`default_nettype none
module ild_holdoff #(
   parameter DEPTH = 7,
   parameter SEL_W = 3
) (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // detection in, delayed detection out
   input wire det_in,
   input wire [SEL_W-1:0] delay_sel,
   output wire det_out
);
   reg [DEPTH-1:0] line;
   wire [DEPTH:0] taps;

   always @(posedge clk)
   begin
      if (sys_rst)
         line <= {DEPTH{1'b0}};
      else
         line <= {line[DEPTH-2:0], det_in};
   end

   // tap 0 is the undelayed detection
   assign taps = {line, det_in};
   assign det_out = taps[delay_sel];
endmodule // ild_holdoff
`default_nettype wire

//--- sim/ild_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ild_top_properties #(
   parameter SAMPLE_W = 14,
   parameter HOLD_DEPTH = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // converter side
   input wire logic [SAMPLE_W-1:0] port_a_sample_bus,
   input wire logic [SAMPLE_W-1:0] port_b_sample_bus,
   input wire logic port_a_input_enable,
   input wire logic port_b_input_enable,
   // microport
   input wire logic up_mode,
   input wire logic up_cs_n,
   input wire logic up_rd_n,
   input wire logic up_wr_n,
   input wire logic [2:0] up_addr,
   input wire logic [7:0] up_data_in,
   input wire logic [7:0] up_data_out,
   input wire logic up_data_oe_n,
   input wire logic up_rdy,
   // indicators
   input wire logic port_a_level_out_primary,
   input wire logic port_a_level_out_secondary,
   input wire logic port_b_level_out_primary,
   input wire logic port_b_level_out_secondary
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // config resets to zero, so every indicator leaves reset low
   wire logic any_ind = port_a_level_out_primary | port_a_level_out_secondary
      | port_b_level_out_primary | port_b_level_out_secondary;
   chk_reset_quiet: assert property (
      $fell(sys_rst) |-> !any_ind && up_data_oe_n && up_rdy)
      else $error("indicator or microport active out of reset");
   chk_rdy_pulse: assert property (
      !up_mode && $fell(up_rdy) |=> !up_rdy ##1 up_rdy)
      else $error("ready low time wrong");
   chk_oe_with_rdy: assert property (
      !up_mode && $fell(up_data_oe_n) |-> $fell(up_rdy))
      else $error("read drive without ready");
   chk_read_stands: assert property (
      !up_data_oe_n && !up_rd_n |=> !up_data_oe_n && $stable(up_data_out))
      else $error("read data dropped while strobe held");
   chk_oe_release: assert property (
      !up_data_oe_n && $rose(up_rd_n) |-> ##[1:8] up_data_oe_n)
      else $error("data bus not released after strobe");
   chk_oe_needs_read: assert property (
      $fell(up_data_oe_n) |-> !$past(up_rd_n, 3) && !$past(up_cs_n, 3))
      else $error("data bus driven without a read");
   chk_write_quiet: assert property (
      !up_cs_n && !up_wr_n && up_rd_n |-> up_data_oe_n)
      else $error("data bus driven during write");
   chk_idle_quiet: assert property (
      up_cs_n [*8] |-> up_rdy && up_data_oe_n)
      else $error("microport busy while deselected");
endmodule // ild_top_properties
bind ild_top ild_top_properties #(.SAMPLE_W(SAMPLE_W), .HOLD_DEPTH(HOLD_DEPTH)) chk_u (
   .clk(clk), .sys_rst(sys_rst), .port_a_sample_bus(port_a_sample_bus),
   .port_b_sample_bus(port_b_sample_bus), .port_a_input_enable(port_a_input_enable),
   .port_b_input_enable(port_b_input_enable), .up_mode(up_mode), .up_cs_n(up_cs_n),
   .up_rd_n(up_rd_n), .up_wr_n(up_wr_n), .up_addr(up_addr), .up_data_in(up_data_in),
   .up_data_out(up_data_out), .up_data_oe_n(up_data_oe_n), .up_rdy(up_rdy),
   .port_a_level_out_primary(port_a_level_out_primary),
   .port_a_level_out_secondary(port_a_level_out_secondary),
   .port_b_level_out_primary(port_b_level_out_primary),
   .port_b_level_out_secondary(port_b_level_out_secondary)
);
`default_nettype wire

//--- sim/ild_adc_model.sv
`timescale 1ns/1ns
`default_nettype none
module ild_adc_model (
   // clock
   input wire logic clk,
   // analog side as set by the bench
   input wire logic [13:0] raw_sample,
   input wire logic raw_enable,
   // converter outputs
   output var logic [13:0] sample_bus,
   output var logic input_enable
);
   // pipelined converter: the gain change shows one cycle late, as in hardware
   always @(posedge clk)
   begin
      sample_bus <= raw_sample;
      input_enable <= raw_enable;
   end
endmodule // ild_adc_model
`default_nettype wire

//--- sim/tb_input_level_detector.sv
`timescale 1ns/1ns
`default_nettype none
module tb_input_level_detector;
   localparam logic [9:0] lo_thr = 10'h040;
   localparam logic [9:0] hi_thr = 10'h200;
   logic clk, sys_rst, ien_a, ien_b, en_a, en_b, cs_n, rd_n, wr_n, oe_n, rdy, mode;
   logic a_p, a_s, b_p, b_s;
   logic [13:0] raw_a, raw_b, smp_a, smp_b;
   logic [2:0] addr;
   logic [7:0] din, dout;
   int err_count, n_tests;

   ild_adc_model adc_a (.clk(clk), .raw_sample(raw_a), .raw_enable(ien_a),
      .sample_bus(smp_a), .input_enable(en_a));
   ild_adc_model adc_b (.clk(clk), .raw_sample(raw_b), .raw_enable(ien_b),
      .sample_bus(smp_b), .input_enable(en_b));
   ild_top dut_u (.clk(clk), .sys_rst(sys_rst), .port_a_sample_bus(smp_a),
      .port_b_sample_bus(smp_b), .port_a_input_enable(en_a), .port_b_input_enable(en_b),
      .up_mode(mode), .up_cs_n(cs_n), .up_rd_n(rd_n), .up_wr_n(wr_n), .up_addr(addr),
      .up_data_in(din), .up_data_out(dout), .up_data_oe_n(oe_n), .up_rdy(rdy),
      .port_a_level_out_primary(a_p), .port_a_level_out_secondary(a_s),
      .port_b_level_out_primary(b_p), .port_b_level_out_secondary(b_s));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one microport access; address and data settle well before the strobe
   task automatic up(input bit rd, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
      int n;
      n = 0;
      addr = a;
      din = d;
      cs_n = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      // mode 1: rd_n is the data strobe, wr_n is read-not-write
      rd_n = !rd && !mode;
      wr_n = rd;
      while (rdy === 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // mode 1 acknowledges with ready low until the strobe goes away
      while (!mode && rdy !== 1'b1 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      q = dout;
      check("access_done", n < 40, 1'b1);
      rd_n = 1'b1;
      wr_n = 1'b1;
      cs_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      up(1'b0, a, d, q);
   endtask

   // upper bytes first: the low byte triggers the internal transfer
   task automatic wr_det(input logic [2:0] loc, input logic [19:0] v);
      wr(3'h6, {5'h00, loc});
      wr(3'h2, {4'h0, v[19:16]});
      wr(3'h1, v[15:8]);
      wr(3'h0, v[7:0]);
   endtask

   task automatic rd_det(input logic [2:0] loc, output logic [19:0] v);
      logic [7:0] d0, d1, d2;
      wr(3'h6, {5'h00, loc});
      up(1'b1, 3'h0, 8'h00, d0);
      up(1'b1, 3'h1, 8'h00, d1);
      up(1'b1, 3'h2, 8'h00, d2);
      v = {d2[3:0], d1, d0};
   endtask

   task automatic setup(input int p, input logic [19:0] dwell, input logic [4:0] cfg);
      wr_det(3'(4 * p), {10'h000, lo_thr});
      wr_det(3'(4 * p + 1), {10'h000, hi_thr});
      wr_det(3'(4 * p + 2), dwell);
      wr_det(3'(4 * p + 3), {15'h0000, cfg});
   endtask

   task automatic drive(input int p, input logic [9:0] m);
      if (p == 1)
         raw_b = {m, 4'h0};
      else
         raw_a = {m, 4'h0};
   endtask

   function automatic logic pin(input int p, input bit sec);
      return (p == 1) ? (sec ? b_s : b_p) : (sec ? a_s : a_p);
   endfunction

   // one sample at m, then samples at the lower threshold; fall counts from last non-low
   task automatic burst(input int p, input bit sec, input bit inact, input logic [9:0] m,
                        input int bump, output int rise, output int fall, output logic other);
      int last;
      last = 0;
      rise = -1;
      fall = -1;
      other = 1'bx;
      drive(p, m);
      for (int n = 1; n < 300 && fall < 0; n++)
      begin
         @(posedge clk);
         #1;
         drive(p, (n == bump) ? lo_thr + 10'h001 : lo_thr);
         if (n == bump)
            last = n;
         if (rise < 0 && pin(p, sec) !== inact)
         begin
            rise = n;
            other = pin(p, !sec);
         end
         else if (rise >= 0 && pin(p, sec) === inact)
            fall = n - last;
      end
   endtask

   task automatic t_regs;
      logic [19:0] v;
      rd_det(3'h3, v);
      check("cfg_reset", v, 20'h00000);
      for (int k = 0; k < 8; k++)
         wr_det(3'(k), 20'hfffff);
      for (int k = 0; k < 8; k++)
      begin
         rd_det(3'(k), v);
         check("reg_rw", v, (k % 4 == 2) ? 20'hfffff : (k % 4 == 3) ? 20'h0001f : 20'h003ff);
      end
      wr(3'h3, 8'h00);
      wr_det(3'h3, 20'h00000);
      rd_det(3'h3, v);
      check("alt_off_read", v, 20'h00000);
      wr(3'h3, 8'h20);
      rd_det(3'h3, v);
      check("alt_on_kept", v, 20'h0001f);
   endtask

   task automatic t_detect(input int p);
      int r0, f0, r1, f1, r3, f3;
      logic o;
      setup(p, 20'd20, 5'h00);
      check("idle_compl", {pin(p, 0), pin(p, 1)}, 2'b01);
      burst(p, 0, 0, hi_thr, 0, r0, f0, o);
      check("rise_at_thr", r0 > 0 && r0 < 12, 1'b1);
      check("active_compl", o, 1'b0);
      check("dwell_span", f0 - r0 >= 20 && f0 - r0 <= 24, 1'b1);
      burst(p, 0, 0, hi_thr, 12, r1, f1, o);
      check("reload_span", f1, f0);
      wr_det(3'(4 * p + 3), 20'h00003);
      burst(p, 0, 0, hi_thr, 0, r3, f3, o);
      check("holdoff_rise", r3 - r0, 3);
      check("holdoff_span", f3 - r3, f0 - r0);
      burst(p, 0, 0, hi_thr - 10'h001, 0, r1, f1, o);
      check("below_thr", r1, -1);
   endtask

   task automatic t_modes(input int p);
      int r, f;
      logic o;
      setup(p, 20'd20, 5'h10);
      check("pol_idle", {pin(p, 0), pin(p, 1)}, 2'b10);
      burst(p, 0, 1, hi_thr, 0, r, f, o);
      check("pol_active", r > 0 && f > 0, 1'b1);
      check("pol_compl", o, 1'b1);
      wr_det(3'(4 * p + 3), 20'h00008);
      if (p == 1)
         ien_b = 1'b1;
      else
         ien_a = 1'b1;
      burst(p, 1, 0, hi_thr, 0, r, f, o);
      check("ilv_high", {r > 0, o}, 2'b10);
      ien_a = 1'b0;
      ien_b = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      burst(p, 0, 0, hi_thr, 0, r, f, o);
      check("ilv_low", {r > 0, o}, 2'b10);
      wr_det(3'(4 * p + 2), 20'h00000);
      burst(p, 0, 0, hi_thr, 0, r, f, o);
      check("dwell_zero", r, -1);
   endtask

   task automatic t_moto;
      logic [19:0] v;
      mode = 1'b1;
      wr_det(3'h2, 20'h5a3c1);
      rd_det(3'h2, v);
      check("mode1_rw", v, 20'h5a3c1);
   endtask

   // a full run needs well under 10000 cycles; twice that means a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish;
   end

   initial
   begin
      sys_rst = 1'b1;
      {mode, ien_a, ien_b, cs_n, rd_n, wr_n} = 6'b000111;
      addr = 3'h0;
      din = 8'h00;
      raw_a = {lo_thr, 4'h0};
      raw_b = {lo_thr, 4'h0};
      err_count = 0;
      n_tests = 0;
      repeat (20) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      @(posedge clk);
      #1;
      check("reset_ind", {a_p, b_p}, 2'b00);
      wr(3'h7, 8'h00);
      wr(3'h3, 8'h20);
      t_regs;
      for (int p = 0; p < 2; p++)
      begin
         t_detect(p);
         t_modes(p);
      end
      t_moto;
      tally_and_finish;
   end
endmodule // tb_input_level_detector
`default_nettype wire
